// [common/lwbsc_pkg.sv]
// Constants and types shared by the late-write burst memory ends.
// Assumes one 125 MHz clock and a synchronous active-high reset at both ends.
package lwbsc_pkg;
	localparam int ADDR_W   = 19;
	localparam int DATA_W   = 18;
	localparam int LANES    = 2;
	localparam int LANE_W   = DATA_W / LANES;
	localparam int BURST_W  = 2;
	// Sleep timing, given directly in clock cycles
	localparam int SLEEP_ENTRY_DELAY_CYC = 2;
	localparam int WAKE_SAMPLE_DELAY_CYC = 2;
	localparam int SLEEP_ENTRY_CNT = SLEEP_ENTRY_DELAY_CYC;
	localparam int WAKE_SAMPLE_CNT = WAKE_SAMPLE_DELAY_CYC;
	localparam int WAKE_W          = 2;
	localparam logic [WAKE_W-1:0] WAKE_LOAD = WAKE_W'(WAKE_SAMPLE_CNT);
	// Read return buffer in the controller
	localparam int RBUF_DEPTH = 2;
	// Pin levels
	localparam logic [2:0] SEL_ACTIVE   = 3'h2;
	localparam logic [2:0] SEL_INACTIVE = 3'h5;
	localparam logic [1:0] LANES_NONE   = 2'h3;

	typedef enum logic [1:0] {
		MODE_IDLE,
		MODE_DESEL,
		MODE_READ,
		MODE_WRITE
	} lwbsc_mode_t;
endpackage : lwbsc_pkg

// [common/lwbsc_if.sv]
// Memory pins between the controller and the late-write burst memory.
// The shared data wire is resolved here from both drive enables.
interface lwbsc_if;
	import lwbsc_pkg::*;
	logic [ADDR_W-1:0] addr;
	logic              clock_hold_n;
	logic              advance_or_load;
	logic              read_not_write;
	logic              lane_low_write_n;
	logic              lane_high_write_n;
	logic              select_first_n;
	logic              select_second;
	logic              select_third_n;
	logic              linear_order_select_n;
	logic              sleep_request;
	logic              out_enable_n;
	logic [DATA_W-1:0] dev_q;
	logic              dev_drive;
	logic [DATA_W-1:0] host_d;
	logic              host_drive;
	logic [DATA_W-1:0] data_bus;

	// Output enable acts without the clock on the memory's drivers
	assign data_bus = (dev_drive && !out_enable_n) ? dev_q :
		host_drive ? host_d : '0;

	modport device (
		input  addr, clock_hold_n, advance_or_load, read_not_write,
		input  lane_low_write_n, lane_high_write_n, select_first_n,
		input  select_second, select_third_n, linear_order_select_n,
		input  sleep_request, data_bus,
		output dev_q, dev_drive
	);
	modport host (
		output addr, clock_hold_n, advance_or_load, read_not_write,
		output lane_low_write_n, lane_high_write_n, select_first_n,
		output select_second, select_third_n, linear_order_select_n,
		output sleep_request, out_enable_n, host_d, host_drive,
		input  data_bus
	);
endinterface : lwbsc_if

// [hdl/lwbsc_device.sv]
// Late-write flow-through burst memory: command decode, burst counter,
// byte-lane writes, clock hold and sleep handling over a word array.
// Assumes the controller runs on the same clock, so pins need no synchroniser.
//
// Operation
// - Continue bursts keep the loaded direction
// - Continue-deselect only follows a deselect
// - Dummy read and write abort do nothing
// - Writes switch data drivers off automatically
// - Hold during read keeps data driven
// - Hold during write keeps bus undriven, no write
// - Low lane enable writes low byte, high high
// - Both lane enables high aborts the write
// - Clock hold high stalls every command; sleep entry and the wake count still run
// - Data undriven from reset until a read
// - Two-bit burst counter wraps every four
// - Every continue-burst cycle in a read or write burst advances the counter; continues after a deselect or idle leave it
// - Sleep request stops input sampling quickly
// - Two cycles after wake before sampling
// - Commands decode only while sleep is low
// - Write data follows command by one cycle
// - Load cycle takes address, read or write
// - Order select picks interleaved or linear burst
// - Unselected load deselects, advances keep deselect
module lwbsc_device
	import lwbsc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Memory pins
	lwbsc_if.device   pins,
	// Status
	output logic      sleeping
);
	localparam int LW = DW / LANES;

	typedef struct packed {
		lwbsc_mode_t        mode;
		logic [AW-1:0]      base;
		logic [BURST_W-1:0] cnt;
		logic               wr_pend;
		logic [AW-1:0]      wr_addr;
		logic [LANES-1:0]   wr_lanes_n;
		logic [DW-1:0]      q;
		logic               drive;
		logic [WAKE_W-1:0]  wake;
		logic               sleeping;
	} lwbsc_dev_t;

	lwbsc_dev_t       r_reg;
	lwbsc_dev_t       r_next;
	logic [DW-1:0]    mem [2**AW];
	logic [LANES-1:0] mem_we;
	logic [AW-1:0]    cur_addr;
	logic [DW-1:0]    rd_word;
	logic             selected;

	assign selected = !pins.select_first_n && pins.select_second
		&& !pins.select_third_n;

	always_comb begin
		r_next   = r_reg;
		mem_we   = '0;
		cur_addr = '0;
		rd_word  = '0;
		if (pins.sleep_request) begin
			// Pending work is dropped; the controller must not leave any
			r_next.mode     = MODE_IDLE;
			r_next.drive    = 1'b0;
			r_next.wr_pend  = 1'b0;
			r_next.wake     = WAKE_LOAD;
			r_next.sleeping = 1'b1;
		end else if (r_reg.wake != '0) begin
			r_next.wake     = r_reg.wake - 1'b1;
			r_next.sleeping = 1'b0;
		end else if (!pins.clock_hold_n) begin
			if (r_reg.wr_pend) begin
				mem_we = ~r_reg.wr_lanes_n;
			end
			r_next.wr_pend = 1'b0;
			r_next.drive   = 1'b0;
			if (!pins.advance_or_load) begin
				if (selected) begin
					r_next.base = pins.addr;
					r_next.cnt  = '0;
					r_next.mode = pins.read_not_write ? MODE_READ : MODE_WRITE;
				end else begin
					r_next.mode = MODE_DESEL;
				end
			end else if (r_reg.mode == MODE_READ || r_reg.mode == MODE_WRITE) begin
				r_next.cnt = r_reg.cnt + 1'b1;
			end
			cur_addr[AW-1:BURST_W] = r_next.base[AW-1:BURST_W];
			cur_addr[BURST_W-1:0] = pins.linear_order_select_n
				? (r_next.base[BURST_W-1:0] ^ r_next.cnt)
				: (r_next.base[BURST_W-1:0] + r_next.cnt);
			rd_word = mem[cur_addr];
			// Forward the lanes being written this edge to a read of the same word
			for (int i = 0; i < LANES; i++) begin
				if (mem_we[i] && r_reg.wr_addr == cur_addr) begin
					rd_word[i*LW +: LW] = pins.data_bus[i*LW +: LW];
				end
			end
			case (r_next.mode)
				MODE_READ: begin
					r_next.q     = rd_word;
					r_next.drive = 1'b1;
				end
				MODE_WRITE: begin
					r_next.wr_addr    = cur_addr;
					r_next.wr_lanes_n = {pins.lane_high_write_n, pins.lane_low_write_n};
					r_next.wr_pend    = (r_next.wr_lanes_n != LANES_NONE);
				end
				default: begin
					r_next.drive = 1'b0;
				end
			endcase
		end else begin
			r_next = r_reg;
			mem_we = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < LANES; i++) begin
			if (mem_we[i]) begin
				mem[r_reg.wr_addr][i*LW +: LW] <= pins.data_bus[i*LW +: LW];
			end
		end
	end

	assign pins.dev_q     = r_reg.q;
	assign pins.dev_drive = r_reg.drive;
	assign sleeping       = r_reg.sleeping;
endmodule : lwbsc_device

// [hdl/lwbsc_host.sv]
// Controller end: turns user requests into memory pin cycles, places
// write data one cycle late and returns read words through a 2-entry buffer.
// Assumes the memory shares this clock.
module lwbsc_host
	import lwbsc_pkg::*;
#(
	parameter int   AW             = ADDR_W,
	parameter int   DW             = DATA_W,
	parameter logic LINEAR_ORDER_N = 1'b1
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           rst,
	// Memory pins
	lwbsc_if.host               pins,
	// Requests
	input  wire logic           req_valid,
	output logic                req_ready,
	input  wire logic           req_write,
	input  wire logic           req_advance,
	input  wire logic [AW-1:0]  req_addr,
	input  wire logic [1:0]     req_lanes_n,
	input  wire logic [DW-1:0]  req_wdata,
	// Read returns
	output logic                rsp_valid,
	input  wire logic           rsp_ready,
	output logic [DW-1:0]       rsp_data,
	// Power
	input  wire logic           sleep_in
);
	typedef struct packed {
		logic              hold_n;
		logic              adv;
		logic              rnw;
		logic [2:0]        sel;
		logic [1:0]        lanes_n;
		logic [AW-1:0]     addr;
		logic              sleep;
		logic              order_n;
		logic [DW-1:0]     d;
		logic              d_oe;
		logic              wst;
		logic [DW-1:0]     wdat;
		logic              rq1;
		logic              rd_pend;
		logic              in_burst;
		logic              dir_write;
		logic [DW-1:0]     e0;
		logic [DW-1:0]     e1;
		logic [1:0]        cnt;
		logic              ready;
		logic              rvalid;
		logic [WAKE_W-1:0] wake;
	} lwbsc_host_t;

	lwbsc_host_t r_reg;
	lwbsc_host_t r_next;
	logic        take;
	logic        wr_op;
	logic [2:0]  load;

	always_comb begin
		r_next       = r_reg;
		take         = req_valid && r_reg.ready;
		wr_op        = 1'b0;
		load         = '0;
		r_next.order_n = LINEAR_ORDER_N;
		r_next.sleep = sleep_in;
		// Read word buffer: pop then push, depth two
		if (rsp_ready && r_reg.cnt != '0) begin
			r_next.e0  = r_reg.e1;
			r_next.cnt = r_reg.cnt - 1'b1;
		end
		if (r_reg.rd_pend) begin
			if (r_next.cnt == '0) begin
				r_next.e0 = pins.data_bus;
			end else begin
				r_next.e1 = pins.data_bus;
			end
			r_next.cnt = r_next.cnt + 1'b1;
		end
		// Late data: moves on one enabled cycle after the command; a hold keeps it
		r_next.d_oe    = r_reg.wst || (r_reg.d_oe && r_reg.hold_n);
		r_next.d       = r_reg.wst ? r_reg.wdat : r_reg.d;
		r_next.wst     = 1'b0;
		r_next.rd_pend = r_reg.rq1;
		r_next.rq1     = 1'b0;
		// Default pin cycle is a deselecting load
		r_next.hold_n  = 1'b0;
		r_next.adv     = 1'b0;
		r_next.sel     = SEL_INACTIVE;
		r_next.lanes_n = LANES_NONE;
		if (sleep_in || r_reg.wake != '0) begin
			r_next.wake     = sleep_in ? WAKE_LOAD : r_reg.wake - 1'b1;
			r_next.in_burst = 1'b0;
		end else if (take) begin
			r_next.lanes_n = req_lanes_n;
			if (req_advance && r_reg.in_burst) begin
				r_next.adv = 1'b1;
				wr_op      = r_reg.dir_write;
			end else begin
				r_next.sel       = SEL_ACTIVE;
				r_next.rnw       = !req_write;
				r_next.addr      = req_addr;
				r_next.in_burst  = 1'b1;
				r_next.dir_write = req_write;
				wr_op            = req_write;
			end
			r_next.wst  = wr_op;
			r_next.wdat = req_wdata;
			r_next.rq1  = !wr_op;
		end else if (r_reg.in_burst) begin
			// Idle inside a burst: hold the memory so the burst can resume
			r_next.hold_n = 1'b1;
		end else begin
			r_next.in_burst = 1'b0;
		end
		// Leave room in the buffer for every read still in flight
		load         = {1'b0, r_next.cnt} + {2'b0, r_next.rq1} + {2'b0, r_next.rd_pend};
		r_next.ready = !sleep_in && r_next.wake == '0 && load < 3'(RBUF_DEPTH);
		// Registered so the valid output comes straight from a flip-flop
		r_next.rvalid = r_next.cnt != '0;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_reg         <= '0;
			r_reg.sel     <= SEL_INACTIVE;
			r_reg.lanes_n <= LANES_NONE;
			r_reg.order_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pins.clock_hold_n          = r_reg.hold_n;
	assign pins.advance_or_load       = r_reg.adv;
	assign pins.read_not_write        = r_reg.rnw;
	assign pins.select_first_n        = r_reg.sel[0];
	assign pins.select_second         = r_reg.sel[1];
	assign pins.select_third_n        = r_reg.sel[2];
	assign pins.lane_low_write_n      = r_reg.lanes_n[0];
	assign pins.lane_high_write_n     = r_reg.lanes_n[1];
	assign pins.addr                  = r_reg.addr;
	assign pins.sleep_request         = r_reg.sleep;
	assign pins.linear_order_select_n = r_reg.order_n;
	assign pins.out_enable_n          = 1'b0;
	assign pins.host_d                = r_reg.d;
	assign pins.host_drive            = r_reg.d_oe;
	assign req_ready                  = r_reg.ready;
	assign rsp_valid                  = r_reg.rvalid;
	assign rsp_data                   = r_reg.e0;
endmodule : lwbsc_host

// [tb/lwbsc_asserts.sv]
// Pin checker for the late-write burst memory pair.
// Assumes one clock and a synchronous active-high reset at both ends.
module lwbsc_asserts
	import lwbsc_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// Host pins
	input wire logic              clock_hold_n,
	input wire logic              advance_or_load,
	input wire logic              read_not_write,
	input wire logic              lane_low_write_n,
	input wire logic              lane_high_write_n,
	input wire logic              select_first_n,
	input wire logic              select_second,
	input wire logic              select_third_n,
	input wire logic              sleep_request,
	input wire logic              out_enable_n,
	input wire logic              host_drive,
	// Memory pins
	input wire logic [DATA_W-1:0] dev_q,
	input wire logic              dev_drive
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] quiet_reg, quiet_next;
	logic       awake, sel_on, load, rd_load, wr_load;

	// Two edges after wake are ignored, so commands count from the third
	always_comb begin
		quiet_next = quiet_reg;
		if (sleep_request)
			quiet_next = 2'h0;
		else if (quiet_reg != 2'h3)
			quiet_next = quiet_reg + 2'h1;
	end
	always_ff @(posedge clk) begin
		quiet_reg <= rst ? 2'h3 : quiet_next;
	end

	assign awake   = !sleep_request && quiet_reg[1];
	assign sel_on  = {select_third_n, select_second, select_first_n} == SEL_ACTIVE;
	assign load    = awake && !clock_hold_n && !advance_or_load;
	assign rd_load = load && sel_on && read_not_write;
	assign wr_load = load && sel_on && !read_not_write;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	property p_read_drive; rd_load |=> dev_drive; endproperty
	a_read_drive: assert property (p_read_drive) else $error("read load not driven");
	property p_write_off; wr_load |=> !dev_drive; endproperty
	a_write_off: assert property (p_write_off) else $error("driver on in write");
	property p_desel_off; load && !sel_on |=> !dev_drive; endproperty
	a_desel_off: assert property (p_desel_off) else $error("deselect left driven");
	property p_hold_read; dev_drive && clock_hold_n && !sleep_request |=> dev_drive && $stable(dev_q); endproperty
	a_hold_read: assert property (p_hold_read) else $error("hold changed read data");
	property p_idle_off; !dev_drive && !rd_load |=> !dev_drive; endproperty
	a_idle_off: assert property (p_idle_off) else $error("drive without read");
	property p_sleep_off; sleep_request |=> !dev_drive; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("driven in sleep");
	property p_wake_wait; $fell(sleep_request) |-> !dev_drive [*3]; endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("sampled too soon after wake");
	property p_late_data; wr_load && !(lane_low_write_n && lane_high_write_n) |=> host_drive; endproperty
	a_late_data: assert property (p_late_data) else $error("write data not one cycle late");
	property p_no_clash; dev_drive && !out_enable_n |-> !host_drive; endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");

	c_read: cover property (rd_load);
	c_write: cover property (wr_load);
	c_hold: cover property (dev_drive && clock_hold_n);
	c_wake: cover property ($fell(sleep_request));
endmodule : lwbsc_asserts

// [tb/tb_lwbsc.sv]
// Bench for the late-write burst memory: two host and memory pairs share every
// request and differ only in burst order; pair 0 interleaves, pair 1 is linear.
module tb_lwbsc
	import lwbsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk = 1'b0, rst = 1'b1, sleep_in = 1'b0;
	logic              req_valid = 1'b0, req_write = 1'b0, req_advance = 1'b0, rsp_ready = 1'b1;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [1:0]        req_lanes_n = 2'h3;
	logic [DATA_W-1:0] req_wdata = '0;
	logic [1:0]        ready, rvalid, asleep;
	logic [DATA_W-1:0] rdata [2];
	int                err_total = 0, n_compared = 0, cyc = 0;

	always #4 clk = ~clk;

	for (genvar g = 0; g < 2; g++) begin : pair
		lwbsc_if bus ();
		lwbsc_host #(.LINEAR_ORDER_N(1'(g == 0))) lwbsc_host_i (.clk(clk), .rst(rst),
			.pins(bus.host), .req_valid(req_valid), .req_ready(ready[g]), .req_write(req_write),
			.req_advance(req_advance), .req_addr(req_addr), .req_lanes_n(req_lanes_n),
			.req_wdata(req_wdata), .rsp_valid(rvalid[g]), .rsp_ready(rsp_ready),
			.rsp_data(rdata[g]), .sleep_in(sleep_in));
		lwbsc_device lwbsc_device_i (.clk(clk), .rst(rst), .pins(bus.device), .sleeping(asleep[g]));
	end

	lwbsc_asserts lwbsc_asserts_i (.clk(clk), .rst(rst),
		.clock_hold_n(pair[0].bus.clock_hold_n), .advance_or_load(pair[0].bus.advance_or_load),
		.read_not_write(pair[0].bus.read_not_write), .lane_low_write_n(pair[0].bus.lane_low_write_n),
		.lane_high_write_n(pair[0].bus.lane_high_write_n),
		.select_first_n(pair[0].bus.select_first_n), .select_second(pair[0].bus.select_second),
		.select_third_n(pair[0].bus.select_third_n), .sleep_request(pair[0].bus.sleep_request),
		.out_enable_n(pair[0].bus.out_enable_n), .host_drive(pair[0].bus.host_drive),
		.dev_q(pair[0].bus.dev_q), .dev_drive(pair[0].bus.dev_drive));

	task automatic check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic issue(logic wr, logic adv, logic [ADDR_W-1:0] a, logic [1:0] ln,
		logic [DATA_W-1:0] d);
		int n;
		@(negedge clk);
		{req_valid, req_write, req_advance, req_addr, req_lanes_n, req_wdata} = {1'b1, wr, adv, a, ln, d};
		// Ready is settled at the falling edge; the take is the next rising edge
		n = 0;
		while (ready !== 2'h3 && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (n == 60)
			err_total++;
		@(posedge clk);
	endtask : issue

	// Reads one word and checks both pairs
	task automatic rd(logic adv, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] ea, logic [DATA_W-1:0] eb);
		issue(1'b0, adv, a, 2'h3, '0);
		@(negedge clk);
		req_valid = 1'b0;
		pop(ea, eb);
	endtask : rd

	task automatic pop(logic [DATA_W-1:0] ea, logic [DATA_W-1:0] eb);
		int n;
		n = 0;
		while (rvalid !== 2'h3 && n < 60) begin
			@(negedge clk);
			n++;
		end
		if (n == 60)
			err_total++;
		check("rsp_data_a", rdata[0], ea);
		check("rsp_data_b", rdata[1], eb);
		// The word leaves at the next rising edge while rsp_ready is high
		@(negedge clk);
	endtask : pop

	task automatic t_lanes();
		logic [DATA_W-1:0] m, d;
		m = 18'h15555;
		issue(1'b1, 1'b0, 19'h00100, 2'h0, m);
		for (int l = 1; l < 4; l++) begin
			d = 18'h2aaaa ^ 18'(l);
			issue(1'b1, 1'b0, 19'h00100, 2'(l), d);
			m = {l[1] ? m[17:9] : d[17:9], l[0] ? m[8:0] : d[8:0]};
			rd(1'b0, 19'h00100, m, m);
		end
	endtask : t_lanes

	task automatic t_burst();
		for (int i = 0; i < 4; i++)
			issue(1'b1, 1'b0, 19'h00200 | 19'(i), 2'h0, 18'h01000 | 18'(i));
		// Slot one is aborted on the way round and rewritten after the wrap
		for (int k = 0; k < 6; k++)
			issue(1'b1, k != 0, 19'h00301, (k == 1) ? 2'h3 : 2'h0, 18'h03300 | 18'(k % 4));
		for (int k = 0; k < 5; k++)
			rd(k != 0, 19'h00201, 18'h01000 | 18'(1 ^ (k % 4)), 18'h01000 | 18'((1 + k) % 4));
		for (int k = 0; k < 4; k++)
			rd(1'b0, 19'h00300 | 19'(k), 18'h03300 | 18'(1 ^ k), 18'h03300 | 18'((k + 3) % 4));
	endtask : t_burst

	// Receiver stall: two reads wait in the buffer, further requests are refused
	task automatic t_stall();
		@(negedge clk);
		rsp_ready = 1'b0;
		issue(1'b0, 1'b0, 19'h00200, 2'h3, '0);
		issue(1'b0, 1'b0, 19'h00202, 2'h3, '0);
		@(negedge clk);
		req_valid = 1'b0;
		repeat (8) @(negedge clk);
		check("req_ready", 18'(ready), 18'h0);
		rsp_ready = 1'b1;
		pop(18'h01000, 18'h01000);
		pop(18'h01002, 18'h01002);
	endtask : t_stall

	task automatic t_sleep();
		@(negedge clk);
		sleep_in = 1'b1;
		repeat (6) @(negedge clk);
		check("sleeping", 18'(asleep), 18'h3);
		check("req_ready", 18'(ready), 18'h0);
		sleep_in = 1'b0;
		@(negedge clk);
		check("req_ready", 18'(ready), 18'h0);
		rd(1'b0, 19'h00203, 18'h01003, 18'h01003);
	endtask : t_sleep

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (2) @(negedge clk);
		t_lanes();
		t_burst();
		t_stall();
		t_sleep();
		results();
	end

	// A hang ends the run as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
endmodule : tb_lwbsc
